// ===== hw/alu_branch_pkg.sv
// constants, operation codes and timing for the execute stage
// assumes a decode stage that resolves operands before handing them over
package alu_branch_pkg;

   // ------------------------------------------------------------
   // status register bit positions
   // ------------------------------------------------------------
   localparam int FLAG_C = 0;
   localparam int FLAG_Z = 1;
   localparam int FLAG_N = 2;
   localparam int FLAG_V = 3;
   localparam int FLAG_S = 4;
   localparam int FLAG_H = 5;
   localparam int FLAG_T = 6;
   localparam int FLAG_I = 7;

   // ------------------------------------------------------------
   // data constants and reset values
   // ------------------------------------------------------------
   localparam logic [7:0] ALL_ONES = 8'hff;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [7:0] SIGN_ONLY = 8'h80;
   localparam logic [7:0] SREG_RESET = 8'h00;

   // ------------------------------------------------------------
   // cycle counts per instruction class
   // ------------------------------------------------------------
   localparam logic [2:0] CYC_SINGLE = 3'h1;
   localparam logic [2:0] CYC_WORD = 3'h2;
   localparam logic [2:0] CYC_PRODUCT = 3'h2;
   localparam logic [2:0] CYC_SHORT_JUMP = 3'h2;
   localparam logic [2:0] CYC_DIRECT_JUMP = 3'h3;
   localparam logic [2:0] CYC_SHORT_CALL = 3'h4;
   localparam logic [2:0] CYC_DIRECT_CALL = 3'h5;
   localparam logic [2:0] CYC_EXIT = 3'h5;
   localparam logic [2:0] CYC_SKIP_ONE = 3'h2;
   localparam logic [2:0] CYC_SKIP_TWO = 3'h3;

   // ------------------------------------------------------------
   // operations
   // ------------------------------------------------------------
   typedef enum logic [5:0] {
      OP_ADD_REGS, OP_ADD_CARRY_REGS, OP_WORD_ADD_IMMEDIATE,
      OP_SUB_REGS, OP_SUB_CONSTANT, OP_SUB_BORROW_REGS, OP_SUB_BORROW_CONSTANT,
      OP_WORD_SUB_IMMEDIATE, OP_AND_REGS, OP_AND_CONSTANT, OP_OR_REGS,
      OP_OR_CONSTANT, OP_XOR_REGS, OP_BITWISE_INVERT, OP_SIGN_FLIP,
      OP_SET_BITS_OP, OP_CLEAR_BITS_OP, OP_ZERO_MINUS_CHECK, OP_CLEAR_REG,
      OP_SET_ALL_ONES, OP_PRODUCT_UNSIGNED, OP_PRODUCT_SIGNED,
      OP_PRODUCT_SIGNED_UNSIGNED, OP_FRACTION_PRODUCT_UNSIGNED,
      OP_FRACTION_PRODUCT_SIGNED, OP_FRACTION_PRODUCT_MIXED,
      OP_RELATIVE_JUMP, OP_INDIRECT_JUMP, OP_DIRECT_JUMP, OP_RELATIVE_CALL,
      OP_INDIRECT_CALL, OP_DIRECT_CALL, OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT,
      OP_SKIP_ON_EQUAL, OP_COMPARE_REGS
   } op_e;

endpackage

// ===== hw/alu_branch_exec.sv
// execute stage for arithmetic, logic, multiply and flow-change operations
// assumes operands, immediates and return address arrive decoded with start

// Behaviour
// RQ1: register add, optionally plus carry, one cycle, sets Z C N V H.
// RQ2: subtract register or constant, optional borrow, one cycle, sets Z C N V H.
// RQ3: word add of constant to register pair, two cycles, sets Z C N V S.
// RQ4: word subtract of constant from register pair, two cycles, sets Z C N V S.
// RQ5: AND with register or constant, one cycle, sets only Z N V.
// RQ6: OR, set-bits and exclusive OR, one cycle, sets only Z N V.
// RQ7: clear-bits ANDs with all-ones minus constant, one cycle, sets Z N V.
// RQ8: invert gives all-ones minus value, one cycle, sets Z N V C.
// RQ9: sign flip gives zero minus value, one cycle, sets Z C N V H.
// RQ10: test ANDs with itself, clear XORs itself, set-all-ones leaves flags.
// RQ11: products write 16 bits to pair 1:0 in two cycles, set Z C.
// RQ12: fractional products shift left one before writing, two cycles, Z C.
// RQ13: jumps leave flags; relative and indirect two cycles, direct three.
// RQ14: short calls four cycles, direct five, exits five; interrupt exit sets I.
// RQ15: skip-on-equal advances PC by one, two or three, takes one to three cycles.
// RQ16: multi-cycle operations stall fetch until their final cycle.
// RQ17: compare sets Z N V C H from the difference without writing back.
module alu_branch_exec #(
   parameter int PC_W = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire alu_branch_pkg::op_e op,
   input wire logic [7:0] rd_val,
   input wire logic [7:0] rd_hi_val,
   input wire logic [7:0] rr_val,
   input wire logic [7:0] imm_val,
   input wire logic [5:0] word_imm,
   input wire logic [PC_W-1:0] pc_val,
   input wire logic [PC_W-1:0] jump_offset,
   input wire logic [PC_W-1:0] jump_target,
   input wire logic [15:0] z_ptr,
   input wire logic [PC_W-1:0] stack_addr,
   input wire logic next_two_word,
   input wire logic [7:0] sreg_in,
   output logic fetch_stall_q,
   output logic done_q,
   output logic wr_en_q,
   output logic wr_pair_q,
   output logic wr_r1r0_q,
   output logic [7:0] res_lo_q,
   output logic [7:0] res_hi_q,
   output logic [7:0] sreg_q,
   output logic [PC_W-1:0] pc_q,
   output logic push_q,
   output logic [PC_W-1:0] push_addr_q,
   output logic pop_q
);

   // ------------------------------------------------------------
   // flag helpers
   // ------------------------------------------------------------
   // returns {h, v, c}
   function automatic logic [2:0] add_hvc(logic [7:0] a, logic [7:0] b, logic [7:0] r);
      return {(a[3] & b[3]) | (b[3] & ~r[3]) | (~r[3] & a[3]),
              (a[7] & b[7] & ~r[7]) | (~a[7] & ~b[7] & r[7]),
              (a[7] & b[7]) | (b[7] & ~r[7]) | (~r[7] & a[7])};
   endfunction

   function automatic logic [2:0] sub_hvc(logic [7:0] a, logic [7:0] b, logic [7:0] r);
      return {(~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]),
              (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]),
              (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7])};
   endfunction

   // ------------------------------------------------------------
   // operation decode and result
   // ------------------------------------------------------------
   logic accept, carry_in, wr_d, pair_d, r1r0_d, push_d, pop_d;
   logic [7:0] lo_d, hi_d, flags_d, opb;
   logic [8:0] sum9, dif9;
   logic [15:0] word_r, word_in, prod, prod_out;
   logic [2:0] hvc, cyc_d;
   logic [PC_W-1:0] pc_d, push_addr_d, pc_one;

   assign accept = start & ~fetch_stall_q;

   always_comb begin
      carry_in = sreg_in[alu_branch_pkg::FLAG_C];
      pc_one = pc_val + PC_W'(1);
      word_in = {rd_hi_val, rd_val};
      opb = (op == alu_branch_pkg::OP_SUB_CONSTANT ||
             op == alu_branch_pkg::OP_SUB_BORROW_CONSTANT) ? imm_val : rr_val; // RQ2
      lo_d = rd_val;
      hi_d = rd_hi_val;
      flags_d = sreg_in;
      wr_d = 1'b0;
      pair_d = 1'b0;
      r1r0_d = 1'b0;
      cyc_d = alu_branch_pkg::CYC_SINGLE;
      pc_d = pc_one;
      push_d = 1'b0;
      push_addr_d = pc_one;
      pop_d = 1'b0;
      sum9 = 9'h000;
      dif9 = 9'h000;
      word_r = word_in;
      prod = 16'h0000;
      prod_out = 16'h0000;
      hvc = 3'h0;
      unique case (op)
         alu_branch_pkg::OP_ADD_REGS, alu_branch_pkg::OP_ADD_CARRY_REGS: begin
            sum9 = {1'b0, rd_val} + {1'b0, rr_val}
               + {8'h00, (op == alu_branch_pkg::OP_ADD_CARRY_REGS) & carry_in}; // RQ1
            lo_d = sum9[7:0];
            hvc = add_hvc(rd_val, rr_val, lo_d);
            wr_d = 1'b1;
            {flags_d[alu_branch_pkg::FLAG_H], flags_d[alu_branch_pkg::FLAG_V],
             flags_d[alu_branch_pkg::FLAG_C]} = hvc; // RQ1
            flags_d[alu_branch_pkg::FLAG_N] = lo_d[7];
            flags_d[alu_branch_pkg::FLAG_Z] = (lo_d == alu_branch_pkg::ZERO_BYTE);
         end
         alu_branch_pkg::OP_SUB_REGS, alu_branch_pkg::OP_SUB_CONSTANT,
         alu_branch_pkg::OP_SUB_BORROW_REGS, alu_branch_pkg::OP_SUB_BORROW_CONSTANT,
         alu_branch_pkg::OP_SIGN_FLIP, alu_branch_pkg::OP_COMPARE_REGS: begin
            if (op == alu_branch_pkg::OP_SIGN_FLIP) begin
               // zero minus the value reuses the subtractor flags
               dif9 = {1'b0, alu_branch_pkg::ZERO_BYTE} - {1'b0, rd_val}; // RQ9
               lo_d = dif9[7:0];
               hvc = sub_hvc(alu_branch_pkg::ZERO_BYTE, rd_val, lo_d);
            end else begin
               dif9 = {1'b0, rd_val} - {1'b0, opb}
                  - {8'h00, (op == alu_branch_pkg::OP_SUB_BORROW_REGS ||
                             op == alu_branch_pkg::OP_SUB_BORROW_CONSTANT) & carry_in};
               lo_d = dif9[7:0];
               hvc = sub_hvc(rd_val, opb, lo_d);
            end
            wr_d = (op != alu_branch_pkg::OP_COMPARE_REGS); // RQ17
            {flags_d[alu_branch_pkg::FLAG_H], flags_d[alu_branch_pkg::FLAG_V],
             flags_d[alu_branch_pkg::FLAG_C]} = hvc; // RQ2
            flags_d[alu_branch_pkg::FLAG_N] = lo_d[7];
            // borrow chains keep Z only if the earlier byte was also zero
            if (op == alu_branch_pkg::OP_SUB_BORROW_REGS ||
                op == alu_branch_pkg::OP_SUB_BORROW_CONSTANT) begin
               flags_d[alu_branch_pkg::FLAG_Z] = (lo_d == alu_branch_pkg::ZERO_BYTE)
                  & sreg_in[alu_branch_pkg::FLAG_Z];
            end else begin
               flags_d[alu_branch_pkg::FLAG_Z] = (lo_d == alu_branch_pkg::ZERO_BYTE);
            end
         end
         alu_branch_pkg::OP_WORD_ADD_IMMEDIATE, alu_branch_pkg::OP_WORD_SUB_IMMEDIATE: begin
            wr_d = 1'b1;
            pair_d = 1'b1;
            cyc_d = alu_branch_pkg::CYC_WORD; // RQ3 RQ4
            if (op == alu_branch_pkg::OP_WORD_ADD_IMMEDIATE) begin
               word_r = word_in + {10'h000, word_imm}; // RQ3
               flags_d[alu_branch_pkg::FLAG_V] = ~rd_hi_val[7] & word_r[15];
               flags_d[alu_branch_pkg::FLAG_C] = ~word_r[15] & rd_hi_val[7];
            end else begin
               word_r = word_in - {10'h000, word_imm}; // RQ4
               flags_d[alu_branch_pkg::FLAG_V] = rd_hi_val[7] & ~word_r[15];
               flags_d[alu_branch_pkg::FLAG_C] = word_r[15] & ~rd_hi_val[7];
            end
            lo_d = word_r[7:0];
            hi_d = word_r[15:8];
            flags_d[alu_branch_pkg::FLAG_N] = word_r[15];
            flags_d[alu_branch_pkg::FLAG_Z] = (word_r == 16'h0000);
            flags_d[alu_branch_pkg::FLAG_S] = word_r[15] ^ flags_d[alu_branch_pkg::FLAG_V];
         end
         alu_branch_pkg::OP_AND_REGS, alu_branch_pkg::OP_AND_CONSTANT,
         alu_branch_pkg::OP_OR_REGS, alu_branch_pkg::OP_OR_CONSTANT,
         alu_branch_pkg::OP_SET_BITS_OP, alu_branch_pkg::OP_XOR_REGS,
         alu_branch_pkg::OP_CLEAR_BITS_OP, alu_branch_pkg::OP_ZERO_MINUS_CHECK,
         alu_branch_pkg::OP_CLEAR_REG: begin
            unique case (op)
               alu_branch_pkg::OP_AND_REGS: lo_d = rd_val & rr_val; // RQ5
               alu_branch_pkg::OP_AND_CONSTANT: lo_d = rd_val & imm_val; // RQ5
               alu_branch_pkg::OP_OR_REGS: lo_d = rd_val | rr_val; // RQ6
               alu_branch_pkg::OP_XOR_REGS: lo_d = rd_val ^ rr_val; // RQ6
               alu_branch_pkg::OP_CLEAR_BITS_OP:
                  lo_d = rd_val & (alu_branch_pkg::ALL_ONES - imm_val); // RQ7
               alu_branch_pkg::OP_ZERO_MINUS_CHECK: lo_d = rd_val & rd_val; // RQ10
               alu_branch_pkg::OP_CLEAR_REG: lo_d = rd_val ^ rd_val; // RQ10
               default: lo_d = rd_val | imm_val; // RQ6
            endcase
            wr_d = 1'b1;
            flags_d[alu_branch_pkg::FLAG_V] = 1'b0; // RQ5 RQ6
            flags_d[alu_branch_pkg::FLAG_N] = lo_d[7];
            flags_d[alu_branch_pkg::FLAG_Z] = (lo_d == alu_branch_pkg::ZERO_BYTE);
         end
         alu_branch_pkg::OP_BITWISE_INVERT: begin
            lo_d = alu_branch_pkg::ALL_ONES - rd_val; // RQ8
            wr_d = 1'b1;
            flags_d[alu_branch_pkg::FLAG_C] = 1'b1;
            flags_d[alu_branch_pkg::FLAG_V] = 1'b0;
            flags_d[alu_branch_pkg::FLAG_N] = lo_d[7];
            flags_d[alu_branch_pkg::FLAG_Z] = (lo_d == alu_branch_pkg::ZERO_BYTE);
         end
         alu_branch_pkg::OP_SET_ALL_ONES: begin
            lo_d = alu_branch_pkg::ALL_ONES; // RQ10
            wr_d = 1'b1;
         end
         alu_branch_pkg::OP_PRODUCT_UNSIGNED, alu_branch_pkg::OP_PRODUCT_SIGNED,
         alu_branch_pkg::OP_PRODUCT_SIGNED_UNSIGNED,
         alu_branch_pkg::OP_FRACTION_PRODUCT_UNSIGNED,
         alu_branch_pkg::OP_FRACTION_PRODUCT_SIGNED,
         alu_branch_pkg::OP_FRACTION_PRODUCT_MIXED: begin
            unique case (op)
               alu_branch_pkg::OP_PRODUCT_SIGNED,
               alu_branch_pkg::OP_FRACTION_PRODUCT_SIGNED:
                  prod = 16'($signed({{8{rd_val[7]}}, rd_val})
                     * $signed({{8{rr_val[7]}}, rr_val})); // RQ11
               alu_branch_pkg::OP_PRODUCT_SIGNED_UNSIGNED,
               alu_branch_pkg::OP_FRACTION_PRODUCT_MIXED:
                  prod = 16'({{8{rd_val[7]}}, rd_val} * {8'h00, rr_val}); // RQ11
               default: prod = 16'({8'h00, rd_val} * {8'h00, rr_val}); // RQ11
            endcase
            prod_out = (op inside {alu_branch_pkg::OP_FRACTION_PRODUCT_UNSIGNED,
               alu_branch_pkg::OP_FRACTION_PRODUCT_SIGNED,
               alu_branch_pkg::OP_FRACTION_PRODUCT_MIXED}) ? {prod[14:0], 1'b0} : prod; // RQ12
            lo_d = prod_out[7:0];
            hi_d = prod_out[15:8];
            wr_d = 1'b1;
            pair_d = 1'b1;
            r1r0_d = 1'b1;
            cyc_d = alu_branch_pkg::CYC_PRODUCT; // RQ11 RQ12
            // carry is the product's top bit before any shift
            flags_d[alu_branch_pkg::FLAG_C] = prod[15];
            flags_d[alu_branch_pkg::FLAG_Z] = (prod_out == 16'h0000);
         end
         alu_branch_pkg::OP_RELATIVE_JUMP: begin
            pc_d = pc_one + jump_offset; // RQ13
            cyc_d = alu_branch_pkg::CYC_SHORT_JUMP;
         end
         alu_branch_pkg::OP_INDIRECT_JUMP: begin
            pc_d = PC_W'(z_ptr); // RQ13
            cyc_d = alu_branch_pkg::CYC_SHORT_JUMP;
         end
         alu_branch_pkg::OP_DIRECT_JUMP: begin
            pc_d = jump_target; // RQ13
            cyc_d = alu_branch_pkg::CYC_DIRECT_JUMP;
         end
         alu_branch_pkg::OP_RELATIVE_CALL, alu_branch_pkg::OP_INDIRECT_CALL: begin
            pc_d = (op == alu_branch_pkg::OP_RELATIVE_CALL) ?
               pc_one + jump_offset : PC_W'(z_ptr); // RQ14
            push_d = 1'b1;
            cyc_d = alu_branch_pkg::CYC_SHORT_CALL;
         end
         alu_branch_pkg::OP_DIRECT_CALL: begin
            // two-word opcode, so the return lands after the address word
            pc_d = jump_target; // RQ14
            push_d = 1'b1;
            push_addr_d = pc_val + PC_W'(2);
            cyc_d = alu_branch_pkg::CYC_DIRECT_CALL;
         end
         alu_branch_pkg::OP_SUBROUTINE_EXIT, alu_branch_pkg::OP_INTERRUPT_EXIT: begin
            pc_d = stack_addr; // RQ14
            pop_d = 1'b1;
            cyc_d = alu_branch_pkg::CYC_EXIT;
            if (op == alu_branch_pkg::OP_INTERRUPT_EXIT) begin
               flags_d[alu_branch_pkg::FLAG_I] = 1'b1; // RQ14
            end
         end
         alu_branch_pkg::OP_SKIP_ON_EQUAL: begin
            if (rd_val == rr_val) begin
               pc_d = pc_val + (next_two_word ? PC_W'(3) : PC_W'(2)); // RQ15
               cyc_d = next_two_word ? alu_branch_pkg::CYC_SKIP_TWO
                                     : alu_branch_pkg::CYC_SKIP_ONE;
            end
         end
      endcase
   end

   // ------------------------------------------------------------
   // sequencing and output registers
   // ------------------------------------------------------------
   logic [2:0] cnt_q, cnt_d;
   logic stall_d, done_d, wr_en_hold_q, push_hold_q, pop_hold_q;

   always_comb begin
      cnt_d = cnt_q;
      stall_d = fetch_stall_q;
      done_d = 1'b0;
      if (accept) begin
         // single-cycle work completes on the accepting edge
         if (cyc_d == alu_branch_pkg::CYC_SINGLE) begin
            done_d = 1'b1;
         end else begin
            cnt_d = cyc_d - 3'h1;
            stall_d = 1'b1; // RQ16
         end
      end else if (fetch_stall_q) begin
         cnt_d = cnt_q - 3'h1;
         if (cnt_q == 3'h1) begin
            stall_d = 1'b0; // RQ16
            done_d = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q <= 3'h0;
         fetch_stall_q <= 1'b0;
         done_q <= 1'b0;
         wr_en_q <= 1'b0;
         wr_pair_q <= 1'b0;
         wr_r1r0_q <= 1'b0;
         res_lo_q <= alu_branch_pkg::ZERO_BYTE;
         res_hi_q <= alu_branch_pkg::ZERO_BYTE;
         sreg_q <= alu_branch_pkg::SREG_RESET;
         pc_q <= '0;
         push_q <= 1'b0;
         push_addr_q <= '0;
         pop_q <= 1'b0;
         wr_en_hold_q <= 1'b0;
         push_hold_q <= 1'b0;
         pop_hold_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         fetch_stall_q <= stall_d;
         done_q <= done_d;
         // data stands from the accepting edge; strobe intents are held for done
         if (accept) begin
            wr_en_hold_q <= wr_d;
            push_hold_q <= push_d;
            pop_hold_q <= pop_d;
            res_lo_q <= lo_d;
            res_hi_q <= hi_d;
            sreg_q <= flags_d;
            pc_q <= pc_d;
            push_addr_q <= push_addr_d;
            wr_pair_q <= pair_d;
            wr_r1r0_q <= r1r0_d;
         end
         wr_en_q <= done_d & (accept ? wr_d : wr_en_hold_q);
         push_q <= done_d & (accept ? push_d : push_hold_q);
         pop_q <= done_d & (accept ? pop_d : pop_hold_q);
      end
   end

endmodule

// ===== testbench/alu_branch_exec_chk.sv
// concurrent checks on the execute stage ports
// assumes one clock domain with a synchronous active-high reset
module alu_branch_exec_chk #(
   parameter int PC_W = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic start,
   input wire alu_branch_pkg::op_e op,
   input wire logic [7:0] rd_val,
   input wire logic [7:0] rr_val,
   input wire logic [7:0] sreg_in,
   input wire logic [PC_W-1:0] pc_val,
   input wire logic [PC_W-1:0] stack_addr,
   input wire logic fetch_stall_q,
   input wire logic done_q,
   input wire logic wr_en_q,
   input wire logic wr_r1r0_q,
   input wire logic [7:0] res_lo_q,
   input wire logic [7:0] sreg_q,
   input wire logic [PC_W-1:0] pc_q,
   input wire logic push_q,
   input wire logic pop_q
);
   // ------------------------------------------------------------
   // properties
   // ------------------------------------------------------------
   logic acc;
   assign acc = start && !fetch_stall_q;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   a_add_result: assert property (acc && op == alu_branch_pkg::OP_ADD_REGS |=>
      done_q && wr_en_q && res_lo_q == $past(rd_val) + $past(rr_val))
      else $error("add result or strobe wrong");
   a_invert_carry: assert property (acc && op == alu_branch_pkg::OP_BITWISE_INVERT |=>
      res_lo_q == ~$past(rd_val) && sreg_q[alu_branch_pkg::FLAG_C])
      else $error("invert result or carry wrong");
   a_ones_keep: assert property (acc && op == alu_branch_pkg::OP_SET_ALL_ONES |=>
      res_lo_q == 8'hff && sreg_q == $past(sreg_in))
      else $error("set all ones changed flags");
   a_product_two: assert property (acc && op == alu_branch_pkg::OP_PRODUCT_UNSIGNED |=>
      fetch_stall_q && !done_q ##1 done_q && wr_en_q && wr_r1r0_q && !fetch_stall_q)
      else $error("product timing wrong");
   a_jump_three: assert property (acc && op == alu_branch_pkg::OP_DIRECT_JUMP |=>
      !done_q ##1 !done_q ##1 (done_q && sreg_q == $past(sreg_in, 3)))
      else $error("direct jump timing or flags wrong");
   a_call_push: assert property (acc && op == alu_branch_pkg::OP_DIRECT_CALL |=>
      (!done_q && fetch_stall_q)[*4] ##1 (done_q && push_q))
      else $error("direct call timing wrong");
   a_exit_pop: assert property (acc && op == alu_branch_pkg::OP_SUBROUTINE_EXIT |=>
      (!done_q)[*4] ##1 (done_q && pop_q && pc_q == $past(stack_addr, 5)))
      else $error("exit timing or address wrong");
   a_skip_next: assert property (acc && op == alu_branch_pkg::OP_SKIP_ON_EQUAL
      && rd_val != rr_val |=> done_q && pc_q == $past(pc_val) + 1'b1)
      else $error("unequal skip address wrong");
   a_stall_end: assert property ($fell(fetch_stall_q) && !$past(rst) |-> done_q)
      else $error("stall dropped without completion");
   a_compare_nowr: assert property (acc && op == alu_branch_pkg::OP_COMPARE_REGS |=>
      done_q && !wr_en_q)
      else $error("compare wrote a result");
endmodule

bind alu_branch_exec alu_branch_exec_chk #(.PC_W(PC_W)) u_alu_branch_exec_chk (
   .clk, .rst, .start, .op, .rd_val, .rr_val, .sreg_in, .pc_val, .stack_addr, .fetch_stall_q,
   .done_q, .wr_en_q, .wr_r1r0_q, .res_lo_q, .sreg_q, .pc_q, .push_q, .pop_q
);

// ===== testbench/alu_branch_exec_tb.sv
// self-checking bench for the execute stage, one task per scenario
// assumes the checker is bound to the design; core clock 100 MHz
module alu_branch_exec_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, fetch_stall_q, done_q, wr_en_q, wr_pair_q, wr_r1r0_q, push_q, pop_q;
   logic rst = 1'b1, start = 1'b0, next_two_word = 1'b0;
   alu_branch_pkg::op_e op = alu_branch_pkg::OP_ADD_REGS;
   logic [7:0] rd_val = 8'h00, rd_hi_val = 8'h00, rr_val = 8'h00, imm_val = 8'h00;
   logic [7:0] sreg_in = 8'h00, res_lo_q, res_hi_q, sreg_q;
   logic [5:0] word_imm = 6'h00;
   logic [15:0] pc_val = 16'h0100, jump_offset = 16'hfffe, jump_target = 16'h2000;
   logic [15:0] z_ptr = 16'h1234, stack_addr = 16'h0456, pc_q, push_addr_q;
   int n_errors = 0;
   int n_tests = 0;

   alu_branch_exec #(.PC_W(16)) u_alu_branch_exec (
      .clk, .rst, .start, .op, .rd_val, .rd_hi_val, .rr_val, .imm_val, .word_imm, .pc_val,
      .jump_offset, .jump_target, .z_ptr, .stack_addr, .next_two_word, .sreg_in,
      .fetch_stall_q, .done_q, .wr_en_q, .wr_pair_q, .wr_r1r0_q, .res_lo_q, .res_hi_q,
      .sreg_q, .pc_q, .push_q, .push_addr_q, .pop_q
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      end
   endtask

   // m: 0 low byte, 1 byte pair, 2 no data result; returns in the done cycle
   task automatic step(input alu_branch_pkg::op_e o, input logic [15:0] ab, input int c,
         input int m, input logic [15:0] er, input logic [7:0] es);
      int n;
      @(negedge clk);
      start = 1'b1;
      op = o;
      rd_val = ab[15:8];
      rr_val = ab[7:0];
      imm_val = ab[7:0];
      @(negedge clk);
      start = 1'b0;
      n = 1;
      while (done_q !== 1'b1 && n < 8) begin
         chk({23'h0, fetch_stall_q}, 24'h1);
         @(negedge clk);
         n++;
      end
      if (n == 8) begin
         chk({23'h0, done_q}, 24'h1);
         end_sim();
      end
      chk(24'(n), 24'(c));
      if (m == 0) chk({16'h0, res_lo_q}, {16'h0, er[7:0]});
      if (m == 1) chk({8'h0, res_hi_q, res_lo_q}, {8'h0, er});
      chk({16'h0, sreg_q}, {16'h0, es});
      chk({22'h0, wr_pair_q, wr_en_q}, {22'h0, m == 1, m != 2});
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_arith();
      step(alu_branch_pkg::OP_ADD_REGS, 16'h0f01, 1, 0, 16'h0010, 8'h20);
      step(alu_branch_pkg::OP_SUB_REGS, 16'h1020, 1, 0, 16'h00f0, 8'h05);
      step(alu_branch_pkg::OP_SUB_CONSTANT, 16'h1020, 1, 0, 16'h00f0, 8'h05);
      sreg_in = 8'h01;
      step(alu_branch_pkg::OP_ADD_CARRY_REGS, 16'hff00, 1, 0, 16'h0000, 8'h23);
      // borrow result zero but old zero clear keeps zero clear
      step(alu_branch_pkg::OP_SUB_BORROW_REGS, 16'h0100, 1, 0, 16'h0000, 8'h00);
      sreg_in = 8'h03;
      step(alu_branch_pkg::OP_SUB_BORROW_CONSTANT, 16'h0100, 1, 0, 16'h0000, 8'h02);
      $display("arith done");
   endtask

   task automatic t_word();
      word_imm = 6'h3f;
      sreg_in = 8'h20;
      step(alu_branch_pkg::OP_WORD_ADD_IMMEDIATE, 16'hff00, 2, 1, 16'h013e, 8'h20);
      word_imm = 6'h01;
      sreg_in = 8'h00;
      step(alu_branch_pkg::OP_WORD_SUB_IMMEDIATE, 16'h0000, 2, 1, 16'hffff, 8'h15);
      $display("word done");
   endtask

   task automatic t_logic();
      sreg_in = 8'h29;
      step(alu_branch_pkg::OP_AND_REGS, 16'hccaa, 1, 0, 16'h0088, 8'h25);
      step(alu_branch_pkg::OP_AND_CONSTANT, 16'hccaa, 1, 0, 16'h0088, 8'h25);
      step(alu_branch_pkg::OP_OR_REGS, 16'hccaa, 1, 0, 16'h00ee, 8'h25);
      step(alu_branch_pkg::OP_OR_CONSTANT, 16'hccaa, 1, 0, 16'h00ee, 8'h25);
      step(alu_branch_pkg::OP_XOR_REGS, 16'hccaa, 1, 0, 16'h0066, 8'h21);
      step(alu_branch_pkg::OP_SET_BITS_OP, 16'hccaa, 1, 0, 16'h00ee, 8'h25);
      step(alu_branch_pkg::OP_CLEAR_BITS_OP, 16'hccaa, 1, 0, 16'h0044, 8'h21);
      $display("logic done");
   endtask

   task automatic t_unary();
      sreg_in = 8'h00;
      step(alu_branch_pkg::OP_BITWISE_INVERT, 16'h0000, 1, 0, 16'h00ff, 8'h05);
      step(alu_branch_pkg::OP_SIGN_FLIP, 16'h8000, 1, 0, 16'h0080, 8'h0d);
      step(alu_branch_pkg::OP_ZERO_MINUS_CHECK, 16'h8000, 1, 0, 16'h0080, 8'h04);
      step(alu_branch_pkg::OP_CLEAR_REG, 16'h5a00, 1, 0, 16'h0000, 8'h02);
      sreg_in = 8'h3f;
      step(alu_branch_pkg::OP_SET_ALL_ONES, 16'h1200, 1, 0, 16'h00ff, 8'h3f);
      $display("unary done");
   endtask

   task automatic t_mul();
      sreg_in = 8'h00;
      step(alu_branch_pkg::OP_PRODUCT_UNSIGNED, 16'hffff, 2, 1, 16'hfe01, 8'h01);
      chk({23'h0, wr_r1r0_q}, 24'h1);
      step(alu_branch_pkg::OP_PRODUCT_UNSIGNED, 16'h0005, 2, 1, 16'h0000, 8'h02);
      step(alu_branch_pkg::OP_PRODUCT_SIGNED, 16'hffff, 2, 1, 16'h0001, 8'h00);
      step(alu_branch_pkg::OP_PRODUCT_SIGNED_UNSIGNED, 16'hff02, 2, 1, 16'hfffe, 8'h01);
      step(alu_branch_pkg::OP_FRACTION_PRODUCT_UNSIGNED, 16'h8080, 2, 1, 16'h8000, 8'h00);
      step(alu_branch_pkg::OP_FRACTION_PRODUCT_SIGNED, 16'h8080, 2, 1, 16'h8000, 8'h00);
      step(alu_branch_pkg::OP_FRACTION_PRODUCT_MIXED, 16'h8080, 2, 1, 16'h8000, 8'h01);
      $display("product done");
   endtask

   task automatic t_flow();
      sreg_in = 8'h3f;
      step(alu_branch_pkg::OP_RELATIVE_JUMP, 16'h0000, 2, 2, 16'h0000, 8'h3f);
      chk({6'h0, push_q, pop_q, pc_q}, 24'h00_00ff);
      step(alu_branch_pkg::OP_INDIRECT_JUMP, 16'h0000, 2, 2, 16'h0000, 8'h3f);
      chk({6'h0, push_q, pop_q, pc_q}, 24'h00_1234);
      step(alu_branch_pkg::OP_DIRECT_JUMP, 16'h0000, 3, 2, 16'h0000, 8'h3f);
      chk({6'h0, push_q, pop_q, pc_q}, 24'h00_2000);
      step(alu_branch_pkg::OP_RELATIVE_CALL, 16'h0000, 4, 2, 16'h0000, 8'h3f);
      chk({6'h0, push_q, pop_q, pc_q}, 24'h02_00ff);
      step(alu_branch_pkg::OP_INDIRECT_CALL, 16'h0000, 4, 2, 16'h0000, 8'h3f);
      chk({6'h0, push_q, pop_q, pc_q}, 24'h02_1234);
      chk({8'h0, push_addr_q}, 24'h00_0101);
      step(alu_branch_pkg::OP_DIRECT_CALL, 16'h0000, 5, 2, 16'h0000, 8'h3f);
      chk({8'h0, push_addr_q}, 24'h00_0102);
      step(alu_branch_pkg::OP_SUBROUTINE_EXIT, 16'h0000, 5, 2, 16'h0000, 8'h3f);
      chk({6'h0, push_q, pop_q, pc_q}, 24'h01_0456);
      step(alu_branch_pkg::OP_INTERRUPT_EXIT, 16'h0000, 5, 2, 16'h0000, 8'hbf);
      $display("flow done");
   endtask

   task automatic t_skip();
      step(alu_branch_pkg::OP_SKIP_ON_EQUAL, 16'h1234, 1, 2, 16'h0000, 8'h3f);
      chk({8'h0, pc_q}, 24'h00_0101);
      step(alu_branch_pkg::OP_SKIP_ON_EQUAL, 16'h5555, 2, 2, 16'h0000, 8'h3f);
      chk({8'h0, pc_q}, 24'h00_0102);
      next_two_word = 1'b1;
      step(alu_branch_pkg::OP_SKIP_ON_EQUAL, 16'h5555, 3, 2, 16'h0000, 8'h3f);
      chk({8'h0, pc_q}, 24'h00_0103);
      sreg_in = 8'h00;
      step(alu_branch_pkg::OP_COMPARE_REGS, 16'h1020, 1, 2, 16'h0000, 8'h05);
      chk({23'h0, wr_en_q}, 24'h0);
      $display("skip and compare done");
   endtask

   initial begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      chk({16'h0, sreg_q}, 24'h0);
      chk({8'h0, pc_q}, 24'h0);
      t_arith();
      t_word();
      t_logic();
      t_unary();
      t_mul();
      t_flow();
      t_skip();
      end_sim();
   end
endmodule
